// ===== hw/dpd_pin_decode.sv
// Purpose: Device-side decode of address-bit and strobe pin functions of a x16 DDR3 part
// Assumes: Commands sampled on the rising edge of clk_link; one beat per link clock
// Notes:   Link logic resets asynchronously from reset_n; clk_sys side only reports status
// Behaviour
// - Read/write with bit ten high auto-precharges bank
// - Precharge: bit ten low one bank, high all
// - Single-bank precharge closes bank on bank address
// - Bit twelve on-the-fly: high full, low chopped
// - Device drives strobes on reads, controller on writes
// - Read strobe edges align with data changes
// - Lower strobe pair times lower byte only
// - Upper strobe pair times upper byte only
// - Strobes used only as differential pairs
// - Low reset pin resets asynchronously, high releases
// - Reset destroys stored array contents
// - All inputs except the reset pin sampled on rising link clock
// - Mode register picks fixed/on-the-fly; bursts uninterruptible

`timescale 1ns/1ps
`default_nettype none

module dpd_pin_decode #(
    parameter int MEM_WORDS = 16,
    parameter int RD_LAT    = 5,
    parameter int WR_LAT    = 5,
    parameter int AP_WAIT   = 4
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          clk_link,
    input  wire logic                          reset_n,
    input  wire logic                          cs_n,
    input  wire logic                          ras_n,
    input  wire logic                          cas_n,
    input  wire logic                          we_n,
    input  wire logic [dpd_pkg::BA_W-1:0]      bank_addr,
    input  wire logic [dpd_pkg::ADDR_W-1:0]    addr,
    input  wire logic [dpd_pkg::LANE_W-1:0]    lower_byte_lanes_in,
    input  wire logic [dpd_pkg::LANE_W-1:0]    upper_byte_lanes_in,
    output logic      [dpd_pkg::LANE_W-1:0]    lower_byte_lanes_out,
    output logic      [dpd_pkg::LANE_W-1:0]    upper_byte_lanes_out,
    output logic                               lower_byte_lanes_oe,
    output logic                               upper_byte_lanes_oe,
    input  wire logic                          lower_byte_strobe_in,
    input  wire logic                          lower_byte_strobe_n_in,
    output logic                               lower_byte_strobe_out,
    output logic                               lower_byte_strobe_n_out,
    output logic                               lower_byte_strobe_oe,
    input  wire logic                          upper_byte_strobe_in,
    input  wire logic                          upper_byte_strobe_n_in,
    output logic                               upper_byte_strobe_out,
    output logic                               upper_byte_strobe_n_out,
    output logic                               upper_byte_strobe_oe,
    output logic      [dpd_pkg::BANKS-1:0]     bank_open_sys,
    output logic                               link_in_reset_sys,
    output logic                               ap_done_sys
);
    import dpd_pkg::*;

    localparam int IDX_W = $clog2(MEM_WORDS);
    localparam logic [CNT_W-1:0] RD_LAT_M1 = CNT_W'(RD_LAT - 1);
    localparam logic [CNT_W-1:0] WR_LAT_M1 = CNT_W'(WR_LAT - 1);
    localparam logic [CNT_W-1:0] AP_CNT    = CNT_W'(AP_WAIT);

    // ---------------- Link reset: asserts at once, releases on clk_link
    logic rstl_meta_ff;
    logic rstl_n_ff;

    always_ff @(posedge clk_link or negedge reset_n) begin
        if (!reset_n) begin
            rstl_meta_ff <= 1'b0;
            rstl_n_ff    <= 1'b0;
        end else begin
            rstl_meta_ff <= 1'b1;
            rstl_n_ff    <= rstl_meta_ff;
        end
    end

    // ---------------- Link domain state
    dpd_state_t                    state_ff,    nxt_state;
    logic [CNT_W-1:0]              lat_ff,      nxt_lat;
    logic [CNT_W-1:0]              beats_ff,    nxt_beats;
    logic [IDX_W-1:0]              col_ff,      nxt_col;
    logic [BANKS-1:0]              open_ff,     nxt_open;
    logic                          ap_pend_ff,  nxt_ap_pend;
    logic [BA_W-1:0]               ap_bank_ff,  nxt_ap_bank;
    logic [CNT_W-1:0]              ap_cnt_ff,   nxt_ap_cnt;
    logic                          ap_tgl_ff,   nxt_ap_tgl;
    logic                          otf_ff,      nxt_otf;
    logic                          chop_ff,     nxt_chop;
    logic [2*LANE_W-1:0]           dq_ff,       nxt_dq;
    logic                          dqs_ff,      nxt_dqs;
    logic                          oe_ff,       nxt_oe;
    logic                          dqs_n_ff,    nxt_dqs_n;
    logic [2*LANE_W-1:0]           mem_ff      [MEM_WORDS];
    logic [2*LANE_W-1:0]           nxt_mem     [MEM_WORDS];

    logic       cmd_valid;
    logic [2:0] cmd;
    logic       addr_bit_ten;
    logic       addr_bit_twelve;
    logic       lo_diff;
    logic       hi_diff;
    logic       take_rw;

    always_comb begin
        cmd_valid       = !cs_n;
        cmd             = {ras_n, cas_n, we_n};
        addr_bit_ten    = addr[AP_BIT];
        addr_bit_twelve = addr[BC_BIT];
        // A strobe pair only counts when its two legs disagree
        lo_diff         = lower_byte_strobe_in != lower_byte_strobe_n_in;
        hi_diff         = upper_byte_strobe_in != upper_byte_strobe_n_in;
        // One auto-precharge engine: new accesses are ignored while it is busy
        take_rw         = cmd_valid && (cmd == CMD_RD || cmd == CMD_WR)
                          && state_ff == DPD_IDLE && !ap_pend_ff;

        nxt_state   = state_ff;
        nxt_lat     = lat_ff;
        nxt_beats   = beats_ff;
        nxt_col     = col_ff;
        nxt_open    = open_ff;
        nxt_ap_pend = ap_pend_ff;
        nxt_ap_bank = ap_bank_ff;
        nxt_ap_cnt  = ap_cnt_ff;
        nxt_ap_tgl  = ap_tgl_ff;
        nxt_otf     = otf_ff;
        nxt_chop    = chop_ff;
        nxt_dq      = dq_ff;
        nxt_dqs     = 1'b0;
        nxt_mem     = mem_ff;

        // Auto-precharge waits for the burst to end, then the row wait
        if (ap_pend_ff && state_ff == DPD_IDLE) begin
            if (ap_cnt_ff == '0) begin
                nxt_open[ap_bank_ff] = 1'b0;
                nxt_ap_pend          = 1'b0;
                nxt_ap_tgl           = !ap_tgl_ff;
            end else begin
                nxt_ap_cnt = ap_cnt_ff - CNT_W'(1);
            end
        end

        if (cmd_valid && cmd == CMD_ACT) begin
            nxt_open[bank_addr] = 1'b1;
        end

        if (cmd_valid && cmd == CMD_PRE) begin
            if (addr_bit_ten) begin
                nxt_open    = '0;
                nxt_ap_pend = 1'b0;
            end else begin
                nxt_open[bank_addr] = 1'b0;
                if (bank_addr == ap_bank_ff) begin
                    nxt_ap_pend = 1'b0;
                end
            end
        end

        if (cmd_valid && cmd == CMD_MRS && bank_addr == MR0_SEL
                && state_ff == DPD_IDLE) begin
            nxt_otf  = addr[1:0] == BL_OTF;
            nxt_chop = addr[1:0] == BL_FIX4;
        end

        case (state_ff)
            DPD_IDLE: begin
                if (take_rw) begin
                    if (otf_ff) begin
                        nxt_beats = addr_bit_twelve ? BEATS_FULL : BEATS_CHOP;
                    end else begin
                        nxt_beats = chop_ff ? BEATS_CHOP : BEATS_FULL;
                    end
                    nxt_col = addr[IDX_W-1:0];
                    if (addr_bit_ten) begin
                        nxt_ap_pend = 1'b1;
                        nxt_ap_bank = bank_addr;
                        nxt_ap_cnt  = AP_CNT;
                    end
                    if (cmd == CMD_RD) begin
                        nxt_lat   = RD_LAT_M1;
                        nxt_state = DPD_RD_WAIT;
                    end else begin
                        nxt_lat   = WR_LAT_M1;
                        nxt_state = DPD_WR_WAIT;
                    end
                end
            end
            DPD_RD_WAIT: begin
                if (lat_ff == '0) begin
                    nxt_state = DPD_RD_BURST;
                    nxt_dq    = mem_ff[col_ff];
                    nxt_dqs   = 1'b1;
                end else begin
                    nxt_lat = lat_ff - CNT_W'(1);
                end
            end
            DPD_RD_BURST: begin
                // Burst runs to its end; commands cannot cut it short
                if (beats_ff == CNT_W'(1)) begin
                    nxt_state = DPD_IDLE;
                end else begin
                    nxt_dq  = mem_ff[col_ff + IDX_W'(1)];
                    nxt_dqs = !dqs_ff;
                end
                nxt_col   = col_ff + IDX_W'(1);
                nxt_beats = beats_ff - CNT_W'(1);
            end
            DPD_WR_WAIT: begin
                if (lat_ff == '0) begin
                    nxt_state = DPD_WR_BURST;
                end else begin
                    nxt_lat = lat_ff - CNT_W'(1);
                end
            end
            DPD_WR_BURST: begin
                if (lo_diff) begin
                    nxt_mem[col_ff][LANE_W-1:0] = lower_byte_lanes_in;
                end
                if (hi_diff) begin
                    nxt_mem[col_ff][2*LANE_W-1:LANE_W] = upper_byte_lanes_in;
                end
                if (beats_ff == CNT_W'(1)) begin
                    nxt_state = DPD_IDLE;
                end
                nxt_col   = col_ff + IDX_W'(1);
                nxt_beats = beats_ff - CNT_W'(1);
            end
            default: nxt_state = DPD_IDLE;
        endcase

        nxt_oe    = nxt_state == DPD_RD_BURST;
        nxt_dqs_n = !nxt_dqs;
    end

    // Reset wipes the array as well as the control state
    always_ff @(posedge clk_link or negedge rstl_n_ff) begin
        if (!rstl_n_ff) begin
            state_ff   <= DPD_IDLE;
            lat_ff     <= '0;
            beats_ff   <= '0;
            col_ff     <= '0;
            open_ff    <= '0;
            ap_pend_ff <= 1'b0;
            ap_bank_ff <= '0;
            ap_cnt_ff  <= '0;
            ap_tgl_ff  <= 1'b0;
            otf_ff     <= 1'b0;
            chop_ff    <= 1'b0;
            dq_ff      <= '0;
            dqs_ff     <= 1'b0;
            oe_ff      <= 1'b0;
            dqs_n_ff   <= 1'b1;
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            state_ff   <= nxt_state;
            lat_ff     <= nxt_lat;
            beats_ff   <= nxt_beats;
            col_ff     <= nxt_col;
            open_ff    <= nxt_open;
            ap_pend_ff <= nxt_ap_pend;
            ap_bank_ff <= nxt_ap_bank;
            ap_cnt_ff  <= nxt_ap_cnt;
            ap_tgl_ff  <= nxt_ap_tgl;
            otf_ff     <= nxt_otf;
            chop_ff    <= nxt_chop;
            dq_ff      <= nxt_dq;
            dqs_ff     <= nxt_dqs;
            oe_ff      <= nxt_oe;
            dqs_n_ff   <= nxt_dqs_n;
            mem_ff     <= nxt_mem;
        end
    end

    // Both byte lanes share timing, each keeps its own strobe pins
    assign lower_byte_lanes_out    = dq_ff[LANE_W-1:0];
    assign upper_byte_lanes_out    = dq_ff[2*LANE_W-1:LANE_W];
    assign lower_byte_lanes_oe     = oe_ff;
    assign upper_byte_lanes_oe     = oe_ff;
    assign lower_byte_strobe_out   = dqs_ff;
    assign lower_byte_strobe_n_out = dqs_n_ff;
    assign lower_byte_strobe_oe    = oe_ff;
    assign upper_byte_strobe_out   = dqs_ff;
    assign upper_byte_strobe_n_out = dqs_n_ff;
    assign upper_byte_strobe_oe    = oe_ff;

    // ---------------- System domain status
    logic [BANKS-1:0] open_meta_ff, open_sync_ff, nxt_open_sys;
    logic             rs_meta_ff,   rs_sync_ff,   nxt_in_reset;
    logic             tg_meta_ff,   tg_sync_ff,   tg_last_ff;
    logic             nxt_ap_done;
    logic [BANKS-1:0] open_sys_ff;
    logic             in_reset_ff;
    logic             ap_done_ff;

    always_comb begin
        // Bits are independent levels, so a skewed capture is harmless
        nxt_open_sys = open_sync_ff;
        nxt_in_reset = !rs_sync_ff;
        // Link reset clears the toggle; that change is no completion
        nxt_ap_done  = (tg_sync_ff != tg_last_ff) && rs_sync_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            open_meta_ff <= '0;
            open_sync_ff <= '0;
            rs_meta_ff   <= 1'b0;
            rs_sync_ff   <= 1'b0;
            tg_meta_ff   <= 1'b0;
            tg_sync_ff   <= 1'b0;
            tg_last_ff   <= 1'b0;
            open_sys_ff  <= '0;
            in_reset_ff  <= 1'b1;
            ap_done_ff   <= 1'b0;
        end else begin
            open_meta_ff <= open_ff;
            open_sync_ff <= open_meta_ff;
            rs_meta_ff   <= rstl_n_ff;
            rs_sync_ff   <= rs_meta_ff;
            tg_meta_ff   <= ap_tgl_ff;
            tg_sync_ff   <= tg_meta_ff;
            tg_last_ff   <= tg_sync_ff;
            open_sys_ff  <= nxt_open_sys;
            in_reset_ff  <= nxt_in_reset;
            ap_done_ff   <= nxt_ap_done;
        end
    end

    assign bank_open_sys     = open_sys_ff;
    assign link_in_reset_sys = in_reset_ff;
    assign ap_done_sys       = ap_done_ff;

    // ---------------- Checks on the link side
    AST_AP_ARM: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        take_rw && addr_bit_ten |=> ap_pend_ff && ap_bank_ff == $past(bank_addr))
        else $error("auto-precharge not armed");

    AST_PRE_ALL: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        cmd_valid && cmd == CMD_PRE && addr_bit_ten |=> open_ff == '0)
        else $error("precharge all left a bank open");

    AST_PRE_ONE: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        cmd_valid && cmd == CMD_PRE && !addr_bit_ten
        |=> !open_ff[$past(bank_addr)] && ($past(ap_pend_ff)
            || (($past(open_ff) ^ open_ff) & ~(BANKS'(1) << $past(bank_addr))) == '0))
        else $error("single precharge missed its bank");

    AST_CHOP: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        take_rw && otf_ff |=> beats_ff == ($past(addr_bit_twelve) ? BEATS_FULL : BEATS_CHOP))
        else $error("burst length wrong for chop select");

    AST_RD_DRIVE: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        (state_ff == DPD_RD_BURST) == (lower_byte_strobe_oe && upper_byte_lanes_oe))
        else $error("strobe drive not matching read burst");

    AST_EDGE: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        $past(state_ff) == DPD_RD_BURST && state_ff == DPD_RD_BURST
        |-> lower_byte_strobe_out != $past(lower_byte_strobe_out))
        else $error("read strobe did not toggle with data");

    AST_LANE_LO: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        state_ff == DPD_WR_BURST && !lo_diff
        |=> mem_ff[$past(col_ff)][LANE_W-1:0] == $past(mem_ff[col_ff][LANE_W-1:0]))
        else $error("lower byte written without its strobe");

    AST_LANE_HI: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        state_ff == DPD_WR_BURST && hi_diff
        |=> mem_ff[$past(col_ff)][2*LANE_W-1:LANE_W] == $past(upper_byte_lanes_in))
        else $error("upper byte not captured");

    AST_DIFF: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        upper_byte_strobe_n_out == !upper_byte_strobe_out)
        else $error("strobe pair not complementary");

    AST_NO_CUT: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        state_ff == DPD_RD_BURST && beats_ff > CNT_W'(1) |=> state_ff == DPD_RD_BURST)
        else $error("read burst cut short");

    AST_AP_HOLD: assert property (@(posedge clk_link) disable iff (!rstl_n_ff)
        ap_pend_ff && state_ff != DPD_IDLE && !(cmd_valid && cmd == CMD_PRE)
        |=> open_ff[ap_bank_ff] == $past(open_ff[ap_bank_ff]))
        else $error("bank closed before burst end");

endmodule : dpd_pin_decode

`default_nettype wire

// ===== hw/dpd_pkg.sv
// Purpose: Shared constants and types for the DDR3 pin-function decode block
// Assumes: x16 part, eight banks, fourteen address lines
// Notes:   Command codes are {ras_n, cas_n, we_n} with the chip select low

package dpd_pkg;
    localparam int ADDR_W = 14;
    localparam int BA_W   = 3;
    localparam int BANKS  = 8;
    localparam int LANE_W = 8;
    localparam int CNT_W  = 8;

    // Address lines that carry a second function
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;

    // Command codes with the chip select low
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;

    // Burst length field of mode register zero
    localparam logic [BA_W-1:0] MR0_SEL    = 3'h0;
    localparam logic [1:0]      BL_FIX8    = 2'h0;
    localparam logic [1:0]      BL_OTF     = 2'h1;
    localparam logic [1:0]      BL_FIX4    = 2'h2;

    // Beats per burst, one beat per link clock
    localparam logic [CNT_W-1:0] BEATS_FULL = 8'h08;
    localparam logic [CNT_W-1:0] BEATS_CHOP = 8'h04;

    typedef enum logic [2:0] {
        DPD_IDLE,
        DPD_RD_WAIT,
        DPD_RD_BURST,
        DPD_WR_WAIT,
        DPD_WR_BURST
    } dpd_state_t;
endpackage : dpd_pkg

// ===== test/ddr3_pin_function_decode_test.sv
// Purpose: Self-checking bench for the pin-function decode block
// Assumes: Array of 16 words shared by all banks; link clock runs free
// Notes:   Read beats are compared against a queue of expected words
`timescale 1ns/1ps
`default_nettype none

module ddr3_pin_function_decode_test;
    import dpd_pkg::*;
    localparam int RD_LAT = 5;
    localparam int WR_LAT = 5;
    logic                 clk_sys = 1'b0;
    logic                 clk_link = 1'b0;
    logic                 rst = 1'b1;
    logic                 reset_n = 1'b0;
    logic                 cs_n, ras_n, cas_n, we_n, lo_s, lo_sn, up_s, up_sn;
    logic [BA_W-1:0]      bank_addr;
    logic [ADDR_W-1:0]    addr;
    logic [LANE_W-1:0]    lo_in, up_in, lo_out, up_out;
    logic                 lo_oe, up_oe, lo_so, lo_sno, lo_soe, up_so, up_sno, up_soe;
    logic [BANKS-1:0]     bank_open;
    logic                 in_reset, ap_done, otf, fix4;
    logic [15:0]          mem [16];
    logic [15:0]          exp_q [$];
    logic [15:0]          exp_word;
    int                   fails = 0;
    int                   check_count = 0;
    int                   ap_seen = 0;
    int                   beat_idx = 0;

    always #25 clk_sys = ~clk_sys;
    always #16 clk_link = ~clk_link;

    dpd_pin_decode #(.MEM_WORDS(16), .RD_LAT(RD_LAT), .WR_LAT(WR_LAT), .AP_WAIT(4)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .reset_n(reset_n),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_addr(bank_addr), .addr(addr),
        .lower_byte_lanes_in(lo_in), .upper_byte_lanes_in(up_in),
        .lower_byte_lanes_out(lo_out), .upper_byte_lanes_out(up_out),
        .lower_byte_lanes_oe(lo_oe), .upper_byte_lanes_oe(up_oe),
        .lower_byte_strobe_in(lo_s), .lower_byte_strobe_n_in(lo_sn),
        .lower_byte_strobe_out(lo_so), .lower_byte_strobe_n_out(lo_sno),
        .lower_byte_strobe_oe(lo_soe), .upper_byte_strobe_in(up_s),
        .upper_byte_strobe_n_in(up_sn), .upper_byte_strobe_out(up_so),
        .upper_byte_strobe_n_out(up_sno), .upper_byte_strobe_oe(up_soe),
        .bank_open_sys(bank_open), .link_in_reset_sys(in_reset), .ap_done_sys(ap_done)
    );

    dpd_ctrl_model #(.WR_LAT(WR_LAT)) ctl_u (
        .clk_link(clk_link), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_addr(bank_addr), .addr(addr), .lo_in(lo_in), .up_in(up_in),
        .lo_s(lo_s), .lo_sn(lo_sn), .up_s(up_s), .up_sn(up_sn)
    );

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic int beats(input logic [ADDR_W-1:0] a);
        return otf ? (a[BC_BIT] ? 8 : 4) : (fix4 ? 4 : 8);
    endfunction

    // Monitor samples at the falling edge, well clear of the launching rise
    always @(negedge clk_link) begin
        if (lo_oe === 1'b1) begin
            exp_word = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
            check("read_word", exp_word, {up_out, lo_out});
            check("strobe_pairs", 16'({4{~beat_idx[0]}} ^ 4'h5),
                  16'({lo_so, lo_sno, up_so, up_sno}));
            check("read_oe", 16'h7, 16'({up_oe, lo_soe, up_soe}));
            beat_idx++;
        end else begin
            beat_idx = 0;
        end
    end

    always @(posedge clk_sys) begin
        if (ap_done === 1'b1) begin
            ap_seen <= ap_seen + 1;
        end
    end

    task automatic do_read(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a, input bit dup);
        int n;
        n = beats(a);
        for (int i = 0; i < n; i++) exp_q.push_back(mem[4'(a[3:0] + i)]);
        ctl_u.send_cmd(CMD_RD, ba, a);
        if (dup) ctl_u.send_cmd(CMD_RD, ba, a);
        repeat (RD_LAT + n + 2) ctl_u.step();
        check("beats_left", 16'h0000, 16'(exp_q.size()));
        check("idle_oe", 16'h0000, 16'({lo_oe, up_oe, lo_soe, up_soe}));
    endtask

    task automatic do_write(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a,
                            input logic [1:0] en);
        int n;
        logic [15:0] d [8];
        n = beats(a);
        for (int i = 0; i < 8; i++) d[i] = 16'($urandom);
        for (int i = 0; i < n; i++) begin
            if (en[0]) mem[4'(a[3:0] + i)][7:0] = d[i][7:0];
            if (en[1]) mem[4'(a[3:0] + i)][15:8] = d[i][15:8];
        end
        ctl_u.send_cmd(CMD_WR, ba, a);
        ctl_u.write_burst(n, d, en);
        repeat (3) ctl_u.step();
    endtask

    task automatic do_mrs(input logic [1:0] bl);
        ctl_u.send_cmd(CMD_MRS, MR0_SEL, {12'h000, bl});
        otf = (bl == BL_OTF);
        fix4 = (bl == BL_FIX4);
        repeat (2) ctl_u.step();
    endtask

    // Open-bank status crosses into clk_sys with a few cycles of lag
    task automatic expect_open(input logic [7:0] e);
        repeat (12) @(posedge clk_sys);
        check("bank_open", 16'(e), 16'(bank_open));
    endtask

    task automatic restart_link();
        #2;
        reset_n = 1'b1;
        mem = '{default: 16'h0000};
        otf = 1'b0;
        fix4 = 1'b0;
        repeat (5) ctl_u.step();
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        fails++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(80787));
        repeat (16) @(posedge clk_sys);
        #2;
        check("in_reset", 16'h0003, 16'({in_reset, lo_sno}));
        rst = 1'b0;
        restart_link();
        ctl_u.send_cmd(CMD_ACT, 3'h2, 14'h0000);
        expect_open(8'h04);
        do_write(3'h2, 14'h1003, 2'h3);
        do_read(3'h2, 14'h0003, 1'b1);
        do_write(3'h2, 14'h000A, 2'h1);
        do_write(3'h2, 14'h000C, 2'h2);
        do_read(3'h2, 14'h000A, 1'b0);
        do_mrs(BL_OTF);
        do_write(3'h2, 14'h0001, 2'h3);
        for (int i = 0; i < 4; i++) begin
            do_read(3'h2, {1'b0, 1'($urandom), 8'h00, 4'($urandom)}, 1'b0);
        end
        do_mrs(BL_FIX4);
        do_read(3'h2, 14'h1000, 1'b0);
        check("ap_idle", 16'h0000, 16'(ap_seen));
        do_read(3'h2, 14'h0400, 1'b0);
        expect_open(8'h00);
        check("ap_count", 16'h0001, 16'(ap_seen));
        for (int b = 1; b < 8; b += 3) ctl_u.send_cmd(CMD_ACT, 3'(b), 14'h0000);
        expect_open(8'h92);
        ctl_u.send_cmd(CMD_PRE, 3'h4, 14'h0000);
        expect_open(8'h82);
        ctl_u.send_cmd(CMD_PRE, 3'h1, 14'h0400);
        expect_open(8'h00);
        reset_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #2;
        check("link_reset", 16'h0003, 16'({in_reset, lo_sno}));
        check("ap_after_reset", 16'h0001, 16'(ap_seen));
        restart_link();
        do_read(3'h2, 14'h0002, 1'b0);
        tally_and_finish();
    end
endmodule // ddr3_pin_function_decode_test

`default_nettype wire

// ===== test/dpd_ctrl_model.sv
// Purpose: Controller-side model driving commands and write bursts into the decode block
// Assumes: Pins change 2 ns after each clk_link rise
// Notes:   Lanes carry junk and strobe pairs sit equal outside write beats
`timescale 1ns/1ps
`default_nettype none

module dpd_ctrl_model #(
    parameter int WR_LAT = 5
) (
    input  wire logic                     clk_link,
    output logic                          cs_n,
    output logic                          ras_n,
    output logic                          cas_n,
    output logic                          we_n,
    output logic [dpd_pkg::BA_W-1:0]      bank_addr,
    output logic [dpd_pkg::ADDR_W-1:0]    addr,
    output logic [dpd_pkg::LANE_W-1:0]    lo_in,
    output logic [dpd_pkg::LANE_W-1:0]    up_in,
    output logic                          lo_s,
    output logic                          lo_sn,
    output logic                          up_s,
    output logic                          up_sn
);
    import dpd_pkg::*;

    task automatic step();
        @(posedge clk_link);
        #2;
    endtask

    // Released lines show junk so a stale value never passes for a beat
    task automatic idle_bus();
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        bank_addr = BA_W'($urandom);
        addr = ADDR_W'($urandom);
        lo_in = LANE_W'($urandom);
        up_in = LANE_W'($urandom);
        {lo_s, lo_sn} = 2'h3;
        {up_s, up_sn} = 2'h3;
    endtask

    task automatic send_cmd(input logic [2:0] op, input logic [BA_W-1:0] ba,
                            input logic [ADDR_W-1:0] a);
        step();
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = op;
        bank_addr = ba;
        addr = a;
        step();
        idle_bus();
    endtask

    // Beat k is sampled at command edge plus WR_LAT plus one plus k
    task automatic write_burst(input int n, input logic [15:0] d [8], input logic [1:0] en);
        repeat (WR_LAT) step();
        for (int k = 0; k < n; k++) begin
            {up_in, lo_in} = d[k];
            lo_s = k[0];
            lo_sn = en[0] ? ~k[0] : k[0];
            up_s = k[0];
            up_sn = en[1] ? ~k[0] : k[0];
            step();
        end
        idle_bus();
    endtask

    initial begin
        idle_bus();
    end
endmodule // dpd_ctrl_model

`default_nettype wire
